// >>> hdl/brightness_pkg.sv
// Shared constants for the automatic brightness controller.
// Assumes a single 200 MHz clock domain and a plain strobe register port.
package brightness_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CTRL         = 8'h00;
  localparam logic [7:0] OFF_TARGET       = 8'h04;
  localparam logic [7:0] OFF_GAIN_LOW     = 8'h08;
  localparam logic [7:0] OFF_GAIN_HIGH    = 8'h0c;
  localparam logic [7:0] OFF_EXP_LOW      = 8'h10;
  localparam logic [7:0] OFF_EXP_HIGH     = 8'h14;
  localparam logic [7:0] OFF_MANUAL_GAIN  = 8'h18;
  localparam logic [7:0] OFF_MANUAL_EXP   = 8'h1c;
  localparam logic [7:0] OFF_EXP_BASE     = 8'h20;
  localparam logic [7:0] OFF_REGION_X     = 8'h24;
  localparam logic [7:0] OFF_REGION_Y     = 8'h28;
  localparam logic [7:0] OFF_REGION_W     = 8'h2c;
  localparam logic [7:0] OFF_REGION_H     = 8'h30;
  localparam logic [7:0] OFF_FRAME_BUDGET = 8'h34;
  localparam logic [7:0] OFF_STATUS       = 8'h38;
  localparam logic [7:0] OFF_APPLIED_GAIN = 8'h3c;
  localparam logic [7:0] OFF_APPLIED_EXP  = 8'h40;

  // ==========================================================================
  // Field positions
  localparam int CTRL_GAIN_MODE_LSB = 0;
  localparam int CTRL_EXP_MODE_LSB  = 2;
  localparam int CTRL_PROFILE_LSB   = 4;
  localparam int STAT_NO_OVERLAP    = 0;
  localparam int STAT_CONFLICT      = 1;
  localparam int STAT_GAIN_LIMIT    = 2;
  localparam int STAT_EXP_LIMIT     = 3;
  localparam int STAT_EXP_BLOCKED   = 4;
  localparam int STAT_CONVERGED     = 5;
  localparam int STAT_FRAME_SLOW    = 6;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_ONCE     = 2'h1;
  localparam logic [1:0] MODE_CONT     = 2'h2;
  localparam logic [1:0] PROF_NONE     = 2'h0;
  localparam logic [1:0] PROF_GAIN_MIN = 2'h1;
  localparam logic [1:0] PROF_EXP_MIN  = 2'h2;

  typedef enum logic {PH_COLLECT, PH_DECIDE} phase_t;

  // ==========================================================================
  // Limits, steps and reset values
  localparam logic [11:0] GAIN_FLOOR_NARROW = 12'h000;
  localparam logic [11:0] GAIN_FLOOR_WIDE   = 12'h040;
  localparam logic [11:0] GAIN_FLOOR_EXT    = 12'h000;
  localparam logic [11:0] GAIN_CEIL_NORMAL  = 12'h3ff;
  localparam logic [11:0] GAIN_CEIL_BINNED  = 12'h200;
  localparam logic [11:0] GAIN_CEIL_EXT     = 12'hfff;
  localparam logic [23:0] EXP_MIN_US        = 24'h000014;
  localparam logic [23:0] EXP_MAX_US        = 24'h0f4240;
  localparam logic [11:0] GAIN_STEP         = 12'h004;
  localparam logic [7:0]  TOLERANCE         = 8'h02;
  localparam logic [7:0]  RST_TARGET        = 8'h80;
  localparam logic [11:0] RST_GAIN_HIGH     = 12'h3ff;
  localparam logic [23:0] RST_EXP_LOW       = 24'h000014;
  localparam logic [23:0] RST_EXP_HIGH      = 24'h0f4240;
  localparam logic [11:0] RST_MANUAL_RAW    = 12'h064;
  localparam logic [7:0]  RST_EXP_BASE      = 8'h14;
  localparam logic [23:0] RST_EXPOSURE      = 24'h0007d0;
  localparam logic [11:0] RST_REGION_SIZE   = 12'hfff;
  localparam logic [23:0] RST_FRAME_BUDGET  = 24'h004000;

endpackage

// >>> hdl/auto_brightness_control.sv
// Automatic gain and exposure control driven by region-one brightness statistics.
// Assumes pixel coordinates are image-window relative and that frame_end_in pulses
// once after the last pixel, with at least one blanking cycle before the next pixel.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module auto_brightness_control
  import brightness_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic        pix_valid_in,
  input  wire logic [15:0] pix_data_in,
  input  wire logic [11:0] pix_x_in,
  input  wire logic [11:0] pix_y_in,
  input  wire logic        frame_end_in,
  input  wire logic        pix_wide_in,
  input  wire logic        binning_in,
  input  wire logic        remove_limits_in,
  input  wire logic        trigger_width_in,
  output logic      [31:0] rd_data_out,
  output logic      [11:0] gain_out,
  output logic      [23:0] exposure_out,
  output logic             frame_slow_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    phase_t      ph;
    logic [1:0]  ag_mode;
    logic [1:0]  ae_mode;
    logic [1:0]  profile;
    logic [7:0]  target;
    logic [11:0] glo;
    logic [11:0] ghi;
    logic [23:0] elo;
    logic [23:0] ehi;
    logic [11:0] man_gain;
    logic [11:0] man_raw;
    logic [7:0]  base;
    logic [11:0] rx;
    logic [11:0] ry;
    logic [11:0] rw;
    logic [11:0] rh;
    logic [23:0] budget;
    logic [11:0] gain;
    logic [23:0] expo;
    logic [31:0] acc_sum;
    logic [23:0] acc_cnt;
    logic [31:0] snap_sum;
    logic [23:0] snap_cnt;
    logic        no_overlap;
    logic        conflict;
    logic        gain_lim;
    logic        exp_lim;
    logic        converged;
    logic        slow;
    logic [31:0] rdata;
  } state_t;

  localparam state_t ST_RESET = '{ph: PH_COLLECT, target: RST_TARGET, ghi: RST_GAIN_HIGH,
                                  elo: RST_EXP_LOW, ehi: RST_EXP_HIGH,
                                  man_raw: RST_MANUAL_RAW, base: RST_EXP_BASE,
                                  rw: RST_REGION_SIZE, rh: RST_REGION_SIZE,
                                  budget: RST_FRAME_BUDGET, expo: RST_EXPOSURE,
                                  default: '0};

  state_t q;
  state_t d;

  function automatic logic [23:0] clamp24(input logic [23:0] v, input logic [23:0] lo,
                                          input logic [23:0] hi);
    clamp24 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ==========================================================================
  // Effective bounds
  logic [11:0] gfloor;
  logic [11:0] gceil;
  logic [11:0] glo_eff;
  logic [11:0] ghi_eff;
  logic [23:0] elo_eff;
  logic [23:0] ehi_eff;
  logic [23:0] glo_w;

  assign gfloor  = remove_limits_in ? GAIN_FLOOR_EXT
                 : (pix_wide_in ? GAIN_FLOOR_WIDE : GAIN_FLOOR_NARROW);
  assign gceil   = remove_limits_in ? GAIN_CEIL_EXT
                 : (binning_in ? GAIN_CEIL_BINNED : GAIN_CEIL_NORMAL);
  assign glo_w   = clamp24({12'h000, q.glo}, {12'h000, gfloor}, {12'h000, gceil});
  assign glo_eff = glo_w[11:0];
  assign ghi_eff = 12'(clamp24({12'h000, q.ghi}, glo_w, {12'h000, gceil}));
  // Exposure bounds keep full 1 us resolution, no time-base rounding
  assign elo_eff = clamp24(q.elo, EXP_MIN_US, EXP_MAX_US);
  assign ehi_eff = clamp24(q.ehi, elo_eff, EXP_MAX_US);

  // ==========================================================================
  // Statistics over region one within the image window
  logic [7:0]  luma;
  logic [12:0] rx_end;
  logic [12:0] ry_end;
  logic        hit;
  logic [31:0] sum_nx;
  logic [23:0] cnt_nx;

  // Wide pixels carry 12 effective bits; the top 8 give the same 0..255 scale
  assign luma   = pix_wide_in ? pix_data_in[11:4] : pix_data_in[7:0];
  assign rx_end = {1'b0, q.rx} + {1'b0, q.rw};
  assign ry_end = {1'b0, q.ry} + {1'b0, q.rh};
  assign hit    = pix_valid_in && (pix_x_in >= q.rx) && ({1'b0, pix_x_in} < rx_end)
               && (pix_y_in >= q.ry) && ({1'b0, pix_y_in} < ry_end);
  assign sum_nx = q.acc_sum + (hit ? {24'h000000, luma} : 32'h00000000);
  assign cnt_nx = q.acc_cnt + (hit ? 24'h000001 : 24'h000000);

  // Compare sum against target*count: avoids a divider for the average
  logic [33:0] goal;
  logic [33:0] band;
  logic [33:0] sum_w;
  logic        dark;
  logic        bright;

  assign goal   = 34'(q.snap_cnt) * 34'(q.target);
  assign band   = 34'(q.snap_cnt) * 34'(TOLERANCE);
  assign sum_w  = {2'b00, q.snap_sum};
  assign dark   = (sum_w + band) < goal;
  assign bright = sum_w > (goal + band);

  // ==========================================================================
  // Mode and step decisions
  logic        ag_on;
  logic        ae_on;
  logic        pair_ok;
  logic        clash;
  logic [23:0] man_exp;
  logic [12:0] gain_up_w;
  logic [11:0] gain_up;
  logic [11:0] gain_dn;
  logic [23:0] exp_step;
  logic [24:0] exp_up_w;
  logic [23:0] exp_up;
  logic [23:0] exp_dn;
  logic        g_top;
  logic        g_bot;
  logic        e_top;
  logic        e_bot;

  assign ag_on     = q.ag_mode != MODE_OFF;
  assign ae_on     = (q.ae_mode != MODE_OFF) && !trigger_width_in;
  assign pair_ok   = (q.profile != PROF_NONE) && (q.ag_mode == MODE_CONT)
                  && (q.ae_mode == MODE_CONT);
  assign clash     = ag_on && ae_on && !pair_ok;
  assign man_exp   = 24'(q.man_raw) * 24'(q.base);
  assign gain_up_w = {1'b0, q.gain} + {1'b0, GAIN_STEP};
  assign gain_up   = gain_up_w[12] ? 12'hfff : gain_up_w[11:0];
  assign gain_dn   = (q.gain < GAIN_STEP) ? 12'h000 : q.gain - GAIN_STEP;
  // Step scales with exposure so long exposures converge in few frames
  assign exp_step  = (q.expo >> 4) + 24'h000001;
  assign exp_up_w  = {1'b0, q.expo} + {1'b0, exp_step};
  assign exp_up    = exp_up_w[24] ? 24'hffffff : exp_up_w[23:0];
  assign exp_dn    = (q.expo < exp_step) ? 24'h000000 : q.expo - exp_step;
  assign g_top     = q.gain >= ghi_eff;
  assign g_bot     = q.gain <= glo_eff;
  assign e_top     = q.expo >= ehi_eff;
  assign e_bot     = q.expo <= elo_eff;

  // ==========================================================================
  // Next state
  always_comb begin
    logic move_g;
    logic move_e;
    logic hit_g;
    logic hit_e;
    logic [11:0] g_new;
    logic [23:0] e_new;
    move_g = 1'b0;
    move_e = 1'b0;
    hit_g  = 1'b0;
    hit_e  = 1'b0;
    g_new  = dark ? gain_up : (bright ? gain_dn : q.gain);
    e_new  = dark ? exp_up : (bright ? exp_dn : q.expo);
    d       = q;
    d.rdata = 32'h00000000;
    d.slow  = q.expo > q.budget;
    d.acc_sum = sum_nx;
    d.acc_cnt = cnt_nx;
    unique case (q.ph)
      PH_COLLECT: begin
        if (frame_end_in) begin
          d.snap_sum = sum_nx;
          d.snap_cnt = cnt_nx;
          d.acc_sum  = 32'h00000000;
          d.acc_cnt  = 24'h000000;
          d.ph       = PH_DECIDE;
        end
      end
      PH_DECIDE: begin
        d.ph = PH_COLLECT;
        d.no_overlap = q.snap_cnt == 24'h000000;
        d.conflict   = clash;
        if (q.snap_cnt == 24'h000000) begin
          if (ag_on) begin
            d.gain = q.man_gain;
          end
          if (ae_on) begin
            d.expo = man_exp;
          end
        end else if (!clash && (ag_on || ae_on)) begin
          d.converged = !dark && !bright;
          if (ag_on && ae_on) begin
            // Minimised parameter moves last when darker, first when brighter
            if (q.profile == PROF_GAIN_MIN) begin
              move_e = dark ? !e_top : (bright ? g_bot : 1'b0);
              move_g = dark ? e_top : (bright ? !g_bot : 1'b0);
            end else begin
              move_g = dark ? !g_top : (bright ? e_bot : 1'b0);
              move_e = dark ? g_top : (bright ? !e_bot : 1'b0);
            end
            hit_g = (dark && g_top && e_top) || (bright && g_bot && e_bot);
            hit_e = hit_g;
          end else begin
            move_g = ag_on;
            move_e = ae_on;
            hit_g  = (dark && g_top) || (bright && g_bot);
            hit_e  = (dark && e_top) || (bright && e_bot);
          end
          if (ag_on) begin
            d.gain     = 12'(clamp24({12'h000, move_g ? g_new : q.gain},
                                     {12'h000, glo_eff}, {12'h000, ghi_eff}));
            d.gain_lim = hit_g;
            if (q.ag_mode == MODE_ONCE && (d.converged || hit_g)) begin
              d.ag_mode = MODE_OFF;
            end
          end
          if (ae_on) begin
            d.expo    = clamp24(move_e ? e_new : q.expo, elo_eff, ehi_eff);
            d.exp_lim = hit_e;
            if (q.ae_mode == MODE_ONCE && (d.converged || hit_e)) begin
              d.ae_mode = MODE_OFF;
            end
          end
        end
      end
    endcase
    // Software writes land after the engine so a manual value wins its cycle
    if (wr_en_in) begin
      unique case (addr_in)
        OFF_CTRL: begin
          d.ag_mode = wr_data_in[CTRL_GAIN_MODE_LSB +: 2];
          d.ae_mode = wr_data_in[CTRL_EXP_MODE_LSB +: 2];
          d.profile = wr_data_in[CTRL_PROFILE_LSB +: 2];
        end
        OFF_TARGET:       d.target = wr_data_in[7:0];
        OFF_GAIN_LOW:     d.glo = wr_data_in[11:0];
        OFF_GAIN_HIGH:    d.ghi = wr_data_in[11:0];
        OFF_EXP_LOW:      d.elo = wr_data_in[23:0];
        OFF_EXP_HIGH:     d.ehi = wr_data_in[23:0];
        OFF_MANUAL_GAIN: begin
          d.man_gain = wr_data_in[11:0];
          d.gain     = wr_data_in[11:0];
        end
        OFF_MANUAL_EXP: begin
          d.man_raw = wr_data_in[11:0];
          d.expo    = 24'(wr_data_in[11:0]) * 24'(q.base);
        end
        OFF_EXP_BASE:     d.base = wr_data_in[7:0];
        OFF_REGION_X:     d.rx = wr_data_in[11:0];
        OFF_REGION_Y:     d.ry = wr_data_in[11:0];
        OFF_REGION_W:     d.rw = wr_data_in[11:0];
        OFF_REGION_H:     d.rh = wr_data_in[11:0];
        OFF_FRAME_BUDGET: d.budget = wr_data_in[23:0];
        default: begin
        end
      endcase
    end
    if (trigger_width_in) begin
      d.ae_mode = MODE_OFF;
    end
    if (rd_en_in) begin
      unique case (addr_in)
        OFF_CTRL:         d.rdata = {26'h0000000, q.profile, q.ae_mode, q.ag_mode};
        OFF_TARGET:       d.rdata = {24'h000000, q.target};
        OFF_GAIN_LOW:     d.rdata = {20'h00000, q.glo};
        OFF_GAIN_HIGH:    d.rdata = {20'h00000, q.ghi};
        OFF_EXP_LOW:      d.rdata = {8'h00, q.elo};
        OFF_EXP_HIGH:     d.rdata = {8'h00, q.ehi};
        OFF_MANUAL_GAIN:  d.rdata = {20'h00000, q.man_gain};
        OFF_MANUAL_EXP:   d.rdata = {20'h00000, q.man_raw};
        OFF_EXP_BASE:     d.rdata = {24'h000000, q.base};
        OFF_REGION_X:     d.rdata = {20'h00000, q.rx};
        OFF_REGION_Y:     d.rdata = {20'h00000, q.ry};
        OFF_REGION_W:     d.rdata = {20'h00000, q.rw};
        OFF_REGION_H:     d.rdata = {20'h00000, q.rh};
        OFF_FRAME_BUDGET: d.rdata = {8'h00, q.budget};
        OFF_STATUS: begin
          d.rdata[STAT_NO_OVERLAP]  = q.no_overlap;
          d.rdata[STAT_CONFLICT]    = q.conflict;
          d.rdata[STAT_GAIN_LIMIT]  = q.gain_lim;
          d.rdata[STAT_EXP_LIMIT]   = q.exp_lim;
          d.rdata[STAT_EXP_BLOCKED] = trigger_width_in;
          d.rdata[STAT_CONVERGED]   = q.converged;
          d.rdata[STAT_FRAME_SLOW]  = q.slow;
        end
        OFF_APPLIED_GAIN: d.rdata = {20'h00000, q.gain};
        OFF_APPLIED_EXP:  d.rdata = {8'h00, q.expo};
        default:          d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q <= ST_RESET;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  assign rd_data_out    = q.rdata;
  assign gain_out       = q.gain;
  assign exposure_out   = q.expo;
  assign frame_slow_out = q.slow;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic quiet;
  assign quiet = clk_en_in && !wr_en_in && !trigger_width_in;

  chk_gain_in_bounds: assert property (
    (q.ph == PH_DECIDE) && quiet && ag_on && !clash && (q.snap_cnt != 24'h000000)
    |=> (gain_out >= $past(glo_eff)) && (gain_out <= $past(ghi_eff)))
    else $error("gain left its bounds after adjust");

  chk_exp_in_bounds: assert property (
    (q.ph == PH_DECIDE) && quiet && ae_on && !clash && (q.snap_cnt != 24'h000000)
    |=> (exposure_out >= $past(elo_eff)) && (exposure_out <= $past(ehi_eff)))
    else $error("exposure left its bounds after adjust");

  chk_gap_gain_manual: assert property (
    (q.ph == PH_DECIDE) && quiet && ag_on && (q.snap_cnt == 24'h000000)
    |=> gain_out == $past(q.man_gain))
    else $error("manual gain not applied without overlap");

  chk_gap_exp_manual: assert property (
    (q.ph == PH_DECIDE) && quiet && ae_on && (q.snap_cnt == 24'h000000)
    |=> exposure_out == $past(man_exp))
    else $error("manual exposure not applied without overlap");

  chk_trig_blocks_exp: assert property (
    trigger_width_in && clk_en_in && !(wr_en_in && (addr_in == OFF_MANUAL_EXP))
    |=> (q.ae_mode == MODE_OFF) && $stable(exposure_out))
    else $error("auto exposure active in trigger width mode");

  chk_once_to_off: assert property (
    (q.ph == PH_DECIDE) && quiet && (q.ag_mode == MODE_ONCE) && !ae_on
    && (q.snap_cnt != 24'h000000) && !dark && !bright
    |=> (q.ag_mode == MODE_OFF) && $stable(gain_out))
    else $error("once mode did not finish at target");

  chk_off_holds_gain: assert property (
    (q.ag_mode == MODE_OFF) && !(wr_en_in && (addr_in == OFF_MANUAL_GAIN))
    |=> $stable(gain_out))
    else $error("gain moved while auto gain off");

  chk_clash_holds: assert property (
    (q.ph == PH_DECIDE) && quiet && clash |=> $stable(gain_out) && $stable(exposure_out)
    && q.conflict)
    else $error("illegal pairing still adjusted");

  chk_manual_exp_scaled: assert property (
    clk_en_in && wr_en_in && (addr_in == OFF_MANUAL_EXP) && !trigger_width_in
    |=> exposure_out == 24'($past(wr_data_in[11:0])) * 24'($past(q.base)))
    else $error("manual exposure not a time-base multiple");

  chk_frame_slow: assert property (
    clk_en_in |=> frame_slow_out == ($past(q.expo) > $past(q.budget)))
    else $error("frame slow flag wrong");

  cov_gain_rises: cover property ((q.ph == PH_DECIDE) && ag_on && dark
    ##1 (gain_out > $past(gain_out)));
  cov_profile_run: cover property ((q.ph == PH_DECIDE) && pair_ok && ae_on && dark);
  cov_once_done: cover property ($fell(q.ag_mode == MODE_ONCE));
  cov_no_overlap: cover property ($rose(q.no_overlap));

endmodule // auto_brightness_control

`default_nettype wire

// >>> dv/test_auto_brightness_control.sv
// Self-checking bench for the automatic brightness controller.
// Assumes the register map and encodings of brightness_pkg; the bench ties clk_en_in, pix_y_in, binning_in and remove_limits_in to constants.
`timescale 1ns/1ps
`default_nettype none
module test_auto_brightness_control
  import brightness_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic        wr_en_in   = 1'b0;
  logic        rd_en_in   = 1'b0;
  logic        pix_valid_in = 1'b0;
  logic [15:0] pix_data_in  = 16'h0;
  logic [11:0] pix_x_in     = 12'h0;
  logic        frame_end_in = 1'b0;
  logic        trigger_width_in = 1'b0;
  logic        pix_wide_in  = 1'b0;
  logic [31:0] rd_data_out;
  logic [11:0] gain_out;
  logic [23:0] exposure_out;
  logic        frame_slow_out;
  logic [31:0] v;
  int          errors = 0;
  int          checks_done = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  // Binning and limit-removal pins stay fixed: the bounds they select are out of scope here
  auto_brightness_control DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .pix_valid_in(pix_valid_in), .pix_data_in(pix_data_in), .pix_x_in(pix_x_in),
    .pix_y_in(12'h000), .frame_end_in(frame_end_in), .pix_wide_in(pix_wide_in), .binning_in(1'b0),
    .remove_limits_in(1'b0), .trigger_width_in(trigger_width_in), .rd_data_out(rd_data_out),
    .gain_out(gain_out), .exposure_out(exposure_out), .frame_slow_out(frame_slow_out));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in) begin wr_en_in <= 1'b1; addr_in <= a; wr_data_in <= d; end
    @(posedge ref_clk_in) wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in) begin rd_en_in <= 1'b1; addr_in <= a; end
    @(posedge ref_clk_in) rd_en_in <= 1'b0;
    #1 d = rd_data_out;
  endtask
  // Four pixels on row 0, then a frame end; outputs settle two edges after it
  task automatic frame(input logic [15:0] p);
    for (int i = 0; i < 4; i++)
      @(posedge ref_clk_in) begin pix_valid_in <= 1'b1; pix_x_in <= 12'(i); pix_data_in <= p; end
    @(posedge ref_clk_in) begin pix_valid_in <= 1'b0; frame_end_in <= 1'b1; end
    @(posedge ref_clk_in) frame_end_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_manual();
    rd(OFF_TARGET, v); chk("target", v, 32'h80);
    rd(8'hfc, v); chk("unmapped", v, 32'h0);
    chk("gain rst", gain_out, 32'h0);
    chk("exp rst", exposure_out, 32'h7d0);
    wr(OFF_MANUAL_GAIN, 32'h50); wr(OFF_MANUAL_EXP, 32'h3);
    #1 chk("manual gain", gain_out, 32'h50);
    chk("manual exp", exposure_out, 32'h3c);
  endtask
  task automatic t_gain();
    wr(OFF_GAIN_HIGH, 32'h58); wr(OFF_CTRL, 32'(MODE_CONT));
    frame(16'h10); chk("gain step", gain_out, 32'h54);
    frame(16'h10); chk("gain step2", gain_out, 32'h58);
    frame(16'h10); chk("gain clamp", gain_out, 32'h58);
    wr(OFF_REGION_X, 32'h100);
    frame(16'h10); chk("no overlap gain", gain_out, 32'h50);
    rd(OFF_STATUS, v); chk("no overlap flag", v & 32'h1, 32'h1);
    wr(OFF_REGION_X, 32'h0);
  endtask
  task automatic t_once();
    wr(OFF_TARGET, 32'h10); wr(OFF_CTRL, 32'(MODE_ONCE));
    // Wide pixel 0x100 carries luma 0x10 on the same 8-bit scale
    @(posedge ref_clk_in) pix_wide_in <= 1'b1;
    frame(16'h100); rd(OFF_CTRL, v); chk("once off", v & 32'h3, 32'h0);
    @(posedge ref_clk_in) pix_wide_in <= 1'b0;
    chk("once keeps", gain_out, 32'h50);
    rd(OFF_STATUS, v); chk("converged", v & 32'h20, 32'h20);
  endtask
  task automatic t_conflict();
    wr(OFF_TARGET, 32'h80); wr(OFF_CTRL, 32'(MODE_CONT) | (32'(MODE_CONT) << 2));
    frame(16'h10); rd(OFF_STATUS, v); chk("conflict", v & 32'h2, 32'h2);
    chk("conflict gain", gain_out, 32'h50);
    chk("conflict exp", exposure_out, 32'h3c);
  endtask
  task automatic t_trigger();
    @(posedge ref_clk_in) trigger_width_in <= 1'b1;
    wr(OFF_CTRL, 32'(MODE_CONT) << 2);
    rd(OFF_CTRL, v); chk("trig blocks", v & 32'hc, 32'h0);
    rd(OFF_STATUS, v); chk("trig flag", v & 32'h10, 32'h10);
    @(posedge ref_clk_in) trigger_width_in <= 1'b0;
  endtask
  task automatic t_exposure();
    wr(OFF_CTRL, 32'(MODE_CONT) << 2);
    // Step of (exp>>4)+1 gives 64, off the 20 us time base grid
    frame(16'h10); chk("exp step", exposure_out, 32'h40);
    wr(OFF_EXP_HIGH, 32'h42);
    frame(16'h10); chk("exp clamp", exposure_out, 32'h42);
    wr(OFF_FRAME_BUDGET, 32'h41);
    @(posedge ref_clk_in) #1;
    chk("frame slow", frame_slow_out, 32'h1);
  endtask
  // Gain-minimum pair: exposure sits at its high bound, so gain takes the step
  task automatic t_profile();
    wr(OFF_CTRL, 32'(MODE_CONT) | (32'(MODE_CONT) << 2) | (32'(PROF_GAIN_MIN) << 4));
    frame(16'h10); chk("profile gain", gain_out, 32'h54);
    chk("profile exp", exposure_out, 32'h42);
    rd(OFF_STATUS, v); chk("profile ok", v & 32'h2, 32'h0);
  endtask
  // ==========================================================================
  // Verdict and run
  task automatic results();
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset_manual();
    t_gain();
    t_once();
    t_conflict();
    t_trigger();
    t_exposure();
    t_profile();
    results();
  end
endmodule // test_auto_brightness_control
`default_nettype wire
